// ### hdl/ubtr_top.sv
// UART with baud divisor, transmit and receive FIFOs, break, IR codec,
// alternate pins and an APB register slave. Assumes one clock, pclk,
// and pin inputs already synchronous to it.
//
// Our own choices: register access over APB and the address map.
`include "ubtr_defs.svh"
`default_nettype none
module ubtr_top
    import ubtr_pkg::*;
#(
    parameter int DEPTH = 4
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        serial_in_pin,
    input  wire logic        alt_serial_in_pin,
    output var  logic        serial_out_pin,
    output var  logic        alt_serial_out_pin,
    output var  logic        irq
);
    localparam int AW = $clog2(DEPTH);

    // The pointer arithmetic relies on wrap-around of a power of two.
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
            $error("DEPTH must be a power of two of at least 2");
        end
    endgenerate

    logic [15:0]   mode_reg;
    logic [15:0]   div_reg;
    logic [15:0]   bcnt_reg;
    logic          tx_en_reg;
    logic          brk_reg;
    logic [1:0]    txsel_reg;
    logic [1:0]    rxsel_reg;
    logic          ovr_reg;
    logic [2:0]    istat_reg;
    logic [2:0]    ien_reg;
    logic [8:0]    txq [DEPTH];
    ubtr_rxent_t   rxq [DEPTH];
    logic [AW:0]   txw_ptr;
    logic [AW:0]   txr_ptr;
    logic [AW:0]   rxw_ptr;
    logic [AW:0]   rxr_ptr;
    ubtr_state_t   tx_state;
    ubtr_state_t   rx_state;
    logic          tx_arm_reg;
    logic          tx_line_reg;
    logic          tx_brk_reg;
    logic          tx_stop_reg;
    logic [4:0]    tx_sub_reg;
    logic [3:0]    tx_cnt_reg;
    logic [8:0]    tx_sh_reg;
    logic [4:0]    rx_sub_reg;
    logic [3:0]    rx_cnt_reg;
    logic [8:0]    rx_sh_reg;
    logic [4:0]    ir_str_reg;
    logic [31:0]   rdata;
    logic          hit;

    // Mode decode shared by both directions.
    logic       hs, alt, infrared_codec_enable, nine, par_en, odd;
    logic [4:0] ovs_m1, half, irpw;
    assign hs     = mode_reg[`UBTR_MODE_HS];
    assign alt    = mode_reg[`UBTR_MODE_ALT];
    assign infrared_codec_enable   = mode_reg[`UBTR_MODE_INFRARED_CODEC_ENABLE];
    assign nine   = mode_reg[`UBTR_MODE_PAR+:2] == 2'b11;
    assign par_en = ^mode_reg[`UBTR_MODE_PAR+:2];
    assign odd    = mode_reg[`UBTR_MODE_PAR+1];
    assign ovs_m1 = hs ? `UBTR_OVS_HI - 5'h01 : `UBTR_OVS_LO - 5'h01;
    assign half   = {1'b0, ovs_m1[4:1]};
    assign irpw   = hs ? `UBTR_IRPW_HI : `UBTR_IRPW_LO;

    // APB handshake terms; every access is answered after one wait-free
    // access phase.
    logic setup, wr, rd, ctrl_wr, div_wr, tx_en_rise;
    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pready & pwrite;
    assign rd      = psel & penable & pready & ~pwrite;
    assign ctrl_wr = wr & (paddr == `UBTR_A_CTRL) & pstrb[0];
    assign div_wr  = wr & (paddr == `UBTR_A_DIV) & (|pstrb[1:0]);
    assign tx_en_rise = ctrl_wr & pwdata[`UBTR_CTRL_TXEN] & ~tx_en_reg;

    // FIFO occupancy.
    logic [AW:0] tx_n, rx_n;
    logic        tx_full, tx_empty, rx_full, rx_empty;
    assign tx_n     = txw_ptr - txr_ptr;
    assign rx_n     = rxw_ptr - rxr_ptr;
    assign tx_full  = tx_n == (AW+1)'(DEPTH);
    assign tx_empty = tx_n == '0;
    assign rx_full  = rx_n == (AW+1)'(DEPTH);
    assign rx_empty = rx_n == '0;

    // A 9-bit character is only taken from a full halfword write.
    logic tx_push, rx_pop;
    assign tx_push = wr & (paddr == `UBTR_A_TXW) & ~tx_full &
                     (nine ? pstrb[1:0] == 2'b11 : pstrb[0]);
    assign rx_pop  = rd & (paddr == `UBTR_A_RXW) & ~rx_empty;

    ubtr_rxent_t rx_head;
    assign rx_head = rxq[rxr_ptr[AW-1:0]];

    // Read mux and address decode; write-only words read as zero.
    always_comb begin
        rdata = 32'h0000_0000;
        hit   = 1'b1;
        case (paddr)
            `UBTR_A_MODE:  rdata = {16'h0000, mode_reg};
            `UBTR_A_CTRL:  rdata = {19'h0_0000, rx_head.framing_error_flag, rx_head.parity_error_flag,
                                    tx_state == UBTR_IDLE && tx_empty,
                                    tx_full, ~rx_empty, 1'b0, ovr_reg,
                                    rxsel_reg, txsel_reg, brk_reg,
                                    tx_en_reg};
            `UBTR_A_TXW:   rdata = 32'h0000_0000;
            `UBTR_A_RXW:   rdata = {23'h00_0000, rx_head.data};
            `UBTR_A_DIV:   rdata = {16'h0000, div_reg};
            `UBTR_A_ISTAT: rdata = {29'h0000_0000, istat_reg};
            `UBTR_A_ICLR:  rdata = 32'h0000_0000;
            `UBTR_A_IEN:   rdata = {29'h0000_0000, ien_reg};
            default:       hit   = 1'b0;
        endcase
    end

    // APB answer: ready in the access phase, error for unmapped offsets.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~hit;
            if (setup && !pwrite) begin
                prdata <= rdata;
            end
        end
    end

    // Software configuration, byte lanes honoured.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg  <= `UBTR_MODE_RST;
            div_reg   <= `UBTR_DIV_RST;
            tx_en_reg <= 1'b0;
            txsel_reg <= 2'b00;
            rxsel_reg <= 2'b00;
            ien_reg   <= 3'b000;
        end else begin
            if (wr && paddr == `UBTR_A_MODE && pstrb[0]) begin
                mode_reg[7:0] <= pwdata[7:0];
            end
            if (wr && paddr == `UBTR_A_MODE && pstrb[1]) begin
                mode_reg[15:8] <= pwdata[15:8];
            end
            if (wr && paddr == `UBTR_A_DIV && pstrb[0]) begin
                div_reg[7:0] <= pwdata[7:0];
            end
            if (wr && paddr == `UBTR_A_DIV && pstrb[1]) begin
                div_reg[15:8] <= pwdata[15:8];
            end
            if (ctrl_wr) begin
                tx_en_reg <= pwdata[`UBTR_CTRL_TXEN];
                txsel_reg <= pwdata[`UBTR_CTRL_TXSEL+:2];
                rxsel_reg <= pwdata[`UBTR_CTRL_RXSEL+:2];
            end
            if (wr && paddr == `UBTR_A_IEN && pstrb[0]) begin
                ien_reg <= pwdata[2:0];
            end
        end
    end

    // Free-running baud timer; a divisor write or a fresh transmit
    // enable restarts it so the first bit is not shortened.
    logic tick;
    assign tick = bcnt_reg == div_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bcnt_reg <= 16'h0000;
        end else if (div_wr || tx_en_rise) begin
            bcnt_reg <= 16'h0000;
        end else if (tick) begin
            bcnt_reg <= 16'h0000;
        end else begin
            bcnt_reg <= bcnt_reg + 16'h0001;
        end
    end

    // Transmit FIFO storage and pointers.
    logic tx_load;
    assign tx_load = tx_state == UBTR_IDLE && tx_en_reg && !tx_empty;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txw_ptr <= '0;
            txr_ptr <= '0;
        end else begin
            if (tx_push) begin
                txq[txw_ptr[AW-1:0]] <= nine ? pwdata[8:0]
                                             : {1'b0, pwdata[7:0]};
                txw_ptr <= txw_ptr + 1'b1;
            end
            if (tx_load) begin
                txr_ptr <= txr_ptr + 1'b1;
            end
        end
    end

    // Character framing at load; a break replaces the data with zeros.
    logic [8:0] tx_d;
    logic       tx_bit_end, tx_done, brk_done;
    assign tx_d       = txq[txr_ptr[AW-1:0]];
    assign tx_bit_end = tick && !tx_arm_reg && tx_sub_reg == ovs_m1;
    assign tx_done    = tx_state == UBTR_STOP && tx_bit_end && !tx_stop_reg;
    assign brk_done   = tx_done && tx_brk_reg;

    // Transmit shifter: start low, LSB first, parity, stop bits high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state    <= UBTR_IDLE;
            tx_arm_reg  <= 1'b0;
            tx_line_reg <= 1'b1;
            tx_brk_reg  <= 1'b0;
            tx_stop_reg <= 1'b0;
            tx_cnt_reg  <= 4'h0;
            tx_sh_reg   <= 9'h000;
        end else begin
            case (tx_state)
                UBTR_IDLE: begin
                    tx_line_reg <= 1'b1;
                    if (tx_load) begin
                        tx_state   <= UBTR_START;
                        tx_arm_reg <= 1'b1;
                        tx_brk_reg <= brk_reg;
                        if (brk_reg) begin
                            tx_sh_reg  <= 9'h000;
                            tx_cnt_reg <= `UBTR_BREAK_BITS;
                        end else if (par_en) begin
                            tx_sh_reg  <= {^tx_d[7:0] ^ odd, tx_d[7:0]};
                            tx_cnt_reg <= 4'h9;
                        end else begin
                            tx_sh_reg  <= tx_d;
                            tx_cnt_reg <= nine ? 4'h9 : 4'h8;
                        end
                    end
                end
                UBTR_START: begin
                    if (tx_arm_reg && tick) begin
                        tx_arm_reg  <= 1'b0;
                        tx_line_reg <= 1'b0;
                    end else if (tx_bit_end) begin
                        tx_state    <= UBTR_DATA;
                        tx_line_reg <= tx_sh_reg[0];
                        tx_sh_reg   <= {1'b0, tx_sh_reg[8:1]};
                        tx_cnt_reg  <= tx_cnt_reg - 4'h1;
                    end
                end
                UBTR_DATA: begin
                    if (tx_bit_end && tx_cnt_reg == 4'h0) begin
                        tx_state    <= UBTR_STOP;
                        tx_line_reg <= 1'b1;
                        tx_stop_reg <= mode_reg[`UBTR_MODE_STOP2];
                    end else if (tx_bit_end) begin
                        tx_line_reg <= tx_sh_reg[0];
                        tx_sh_reg   <= {1'b0, tx_sh_reg[8:1]};
                        tx_cnt_reg  <= tx_cnt_reg - 4'h1;
                    end
                end
                UBTR_STOP: begin
                    if (tx_bit_end) begin
                        tx_stop_reg <= 1'b0;
                    end
                    if (tx_done) begin
                        tx_state <= UBTR_IDLE;
                    end
                end
                default: tx_state <= UBTR_IDLE;
            endcase
        end
    end

    // Tick count within the current transmit bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_sub_reg <= 5'h00;
        end else if (tx_arm_reg || tx_state == UBTR_IDLE) begin
            tx_sub_reg <= 5'h00;
        end else if (tick) begin
            tx_sub_reg <= tx_bit_end ? 5'h00 : tx_sub_reg + 5'h01;
        end
    end

    // Break request: software sets it; a software write in the same
    // cycle as the end of the break wins over the hardware clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brk_reg <= 1'b0;
        end else if (ctrl_wr) begin
            brk_reg <= pwdata[`UBTR_CTRL_BRK];
        end else if (brk_done) begin
            brk_reg <= 1'b0;
        end
    end

    // Receive line: pin select, then optional IR pulse stretching.
    logic rx_pin, rx_line;
    assign rx_pin  = alt ? alt_serial_in_pin : serial_in_pin;
    assign rx_line = infrared_codec_enable ? (ir_str_reg == 5'h00 && !rx_pin)
                          : rx_pin;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ir_str_reg <= 5'h00;
        end else if (rx_pin) begin
            ir_str_reg <= ovs_m1;
        end else if (tick && ir_str_reg != 5'h00) begin
            ir_str_reg <= ir_str_reg - 5'h01;
        end
    end

    // Receive sampler: mid-bit sampling, false starts rejected.
    logic       rx_end, rx_push, rx_parity_error_flag;
    ubtr_rxent_t rx_ent;
    assign rx_end  = rx_state == UBTR_STOP && tick && rx_sub_reg == ovs_m1;
    assign rx_push = rx_end && !rx_full;
    assign rx_parity_error_flag = par_en && (rx_sh_reg[8] ^ (^rx_sh_reg[7:0]) ^ odd);
    always_comb begin
        rx_ent.framing_error_flag = ~rx_line;
        rx_ent.parity_error_flag = rx_parity_error_flag;
        if (nine) begin
            rx_ent.data = rx_sh_reg;
        end else if (par_en) begin
            rx_ent.data = {1'b0, rx_sh_reg[7:0]};
        end else begin
            rx_ent.data = {1'b0, rx_sh_reg[8:1]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state   <= UBTR_IDLE;
            rx_sub_reg <= 5'h00;
            rx_cnt_reg <= 4'h0;
            rx_sh_reg  <= 9'h000;
        end else if (tick) begin
            rx_sub_reg <= rx_sub_reg + 5'h01;
            case (rx_state)
                UBTR_IDLE: begin
                    rx_sub_reg <= 5'h00;
                    if (!rx_line) begin
                        rx_state <= UBTR_START;
                    end
                end
                UBTR_START: begin
                    if (rx_sub_reg == half) begin
                        rx_sub_reg <= 5'h00;
                        rx_cnt_reg <= (nine || par_en) ? 4'h9 : 4'h8;
                        rx_state   <= rx_line ? UBTR_IDLE : UBTR_DATA;
                    end
                end
                UBTR_DATA: begin
                    if (rx_sub_reg == ovs_m1) begin
                        rx_sub_reg <= 5'h00;
                        rx_sh_reg  <= {rx_line, rx_sh_reg[8:1]};
                        rx_cnt_reg <= rx_cnt_reg - 4'h1;
                        if (rx_cnt_reg == 4'h1) begin
                            rx_state <= UBTR_STOP;
                        end
                    end
                end
                UBTR_STOP: begin
                    if (rx_end) begin
                        rx_state <= UBTR_IDLE;
                    end
                end
                default: rx_state <= UBTR_IDLE;
            endcase
        end
    end

    // Receive FIFO; a character arriving while it is full is dropped.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxw_ptr <= '0;
            rxr_ptr <= '0;
        end else begin
            if (rx_push) begin
                rxq[rxw_ptr[AW-1:0]] <= rx_ent;
                rxw_ptr <= rxw_ptr + 1'b1;
            end
            if (rx_pop) begin
                rxr_ptr <= rxr_ptr + 1'b1;
            end
        end
    end

    // Overrun stays until software writes a zero; a new overrun wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr_reg <= 1'b0;
        end else if (rx_end && rx_full) begin
            ovr_reg <= 1'b1;
        end else if (ctrl_wr && !pwdata[`UBTR_CTRL_OVR]) begin
            ovr_reg <= 1'b0;
        end
    end

    // Interrupt event selection.
    logic       tx_evt, rx_evt, err_evt;
    logic [2:0] evt, clr;
    always_comb begin
        case (txsel_reg)
            2'b01:   tx_evt = tx_done && tx_empty && !tx_en_rise;
            2'b10:   tx_evt = tx_load && tx_n == (AW+1)'(1);
            default: tx_evt = tx_load;
        endcase
        case (rxsel_reg)
            2'b10:   rx_evt = rx_push && rx_n == (AW+1)'(DEPTH - 2);
            2'b11:   rx_evt = rx_push && rx_n == (AW+1)'(DEPTH - 1);
            default: rx_evt = rx_push;
        endcase
    end
    assign err_evt = (rx_end && rx_full) ||
                     (rx_push && (rx_ent.parity_error_flag || rx_ent.framing_error_flag));
    assign evt = {err_evt, rx_evt, tx_evt | tx_en_rise};
    assign clr = (wr && paddr == `UBTR_A_ICLR && pstrb[0]) ? pwdata[2:0]
                                                           : 3'b000;

    // Sticky status: an event in the clearing cycle is kept.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_reg <= 3'b000;
            irq       <= 1'b0;
        end else begin
            istat_reg <= (istat_reg & ~clr) | evt;
            irq       <= |(istat_reg & ien_reg);
        end
    end

    // Pin drivers; the unused pin pair idles high.
    logic tx_val;
    assign tx_val = infrared_codec_enable ? (!tx_line_reg && tx_sub_reg < irpw)
                         : tx_line_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out_pin     <= 1'b1;
            alt_serial_out_pin <= 1'b1;
        end else begin
            serial_out_pin     <= alt ? 1'b1 : tx_val;
            alt_serial_out_pin <= alt ? tx_val : 1'b1;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_div_clear: assert property (div_wr |=> bcnt_reg == 16'h0000)
        else $error("baud timer not cleared by divisor write");
    a_txen_irq: assert property (tx_en_rise |=> istat_reg[0])
        else $error("transmit enable did not raise tx status");
    a_lo_bitlen: assert property (tx_bit_end && !hs |->
        tx_sub_reg == 5'd15) else $error("normal bit not 16 ticks");
    a_hi_bitlen: assert property (tx_bit_end && hs |->
        tx_sub_reg == 5'd3) else $error("high speed bit not 4 ticks");
    a_start_tick: assert property (tx_state == UBTR_START && tx_arm_reg &&
        !tick |=> tx_line_reg)
        else $error("start bit began before a baud tick");
    a_ovr_sticky: assert property (ovr_reg && !ctrl_wr |=> ovr_reg)
        else $error("overrun flag cleared without software");
    a_rx_advance: assert property (rx_pop |=>
        rxr_ptr == $past(rxr_ptr) + 1'b1)
        else $error("receive read did not advance FIFO");
    a_break_clear: assert property (brk_done && !ctrl_wr |=>
        !brk_reg ##[0:2] tx_state != UBTR_STOP)
        else $error("break request not cleared after break");
    a_alt_pins: assert property (alt |=> serial_out_pin)
        else $error("primary pin driven while alternate selected");
    a_fifo_bound: assert property (tx_n <= (AW+1)'(DEPTH) &&
        rx_n <= (AW+1)'(DEPTH)) else $error("FIFO count past depth");

    c_break: cover property (brk_done);
    c_rx_full: cover property (rx_push && rx_n == (AW+1)'(DEPTH - 1));
    c_nine: cover property (tx_load && nine);
    c_overrun: cover property (rx_end && rx_full);
endmodule
`default_nettype wire

// ### hdl/ubtr_defs.svh
// Register offsets, field positions, reset values and bit-time counts
// for the UART block. Assumes an 8-bit APB byte address.
`ifndef UBTR_DEFS_SVH
`define UBTR_DEFS_SVH
`define UBTR_A_MODE    8'h00
`define UBTR_A_CTRL    8'h04
`define UBTR_A_TXW     8'h08
`define UBTR_A_RXW     8'h0C
`define UBTR_A_DIV     8'h10
`define UBTR_A_ISTAT   8'h14
`define UBTR_A_ICLR    8'h18
`define UBTR_A_IEN     8'h1C
`define UBTR_MODE_STOP2 0
`define UBTR_MODE_PAR   1
`define UBTR_MODE_HS    3
`define UBTR_MODE_ALT   10
`define UBTR_MODE_INFRARED_CODEC_ENABLE  12
`define UBTR_CTRL_TXEN  0
`define UBTR_CTRL_BRK   1
`define UBTR_CTRL_TXSEL 2
`define UBTR_CTRL_RXSEL 4
`define UBTR_CTRL_OVR   6
`define UBTR_IRQ_TX     0
`define UBTR_IRQ_RX     1
`define UBTR_IRQ_ERR    2
`define UBTR_MODE_RST   16'h0000
`define UBTR_DIV_RST    16'h0000
`define UBTR_OVS_LO     5'h10
`define UBTR_OVS_HI     5'h04
`define UBTR_IRPW_LO    5'h03
`define UBTR_IRPW_HI    5'h01
`define UBTR_BREAK_BITS 4'hC
`endif

// ### hdl/ubtr_pkg.sv
// Types shared by the UART block: state encoding and FIFO entry.
// Assumes nothing of its surroundings.
`default_nettype none
package ubtr_pkg;
    typedef enum logic [1:0] {
        UBTR_IDLE  = 2'b00,
        UBTR_START = 2'b01,
        UBTR_DATA  = 2'b11,
        UBTR_STOP  = 2'b10
    } ubtr_state_t;
    typedef struct packed {
        logic       framing_error_flag;
        logic       parity_error_flag;
        logic [8:0] data;
    } ubtr_rxent_t;
endpackage
`default_nettype wire

// ### tb/ubtr_peer.sv
// Far-side serial peer: sends 8N1 frames in, captures frames out.
// Assumes the bench calls its tasks with a bit time in pclk cycles.
`default_nettype none
module ubtr_peer (
    input  wire logic pclk,
    input  wire logic line_in,
    output var  logic line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // The line rests high between frames.
    initial line_out = 1'b1;
    // Start bit, data LSB first, then one stop bit.
    task automatic send(input logic [7:0] d, input int bt);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out <= f[i];
            repeat (bt) @(posedge pclk);
        end
    endtask
    // Sampling at mid bit also catches a wrong bit time.
    task automatic recv(input int bt, output logic [9:0] f);
        int k;
        k = 0;
        while (line_in !== 1'b0 && k < 20000) begin
            @(posedge pclk);
            k++;
        end
        repeat (bt / 2) @(posedge pclk);
        for (int i = 0; i < 10; i++) begin
            f[i] = line_in;
            repeat (bt) @(posedge pclk);
        end
    endtask
endmodule
`default_nettype wire

// ### tb/tb_uart_baud_tx_rx_sequencing.sv
// Bench for the UART: APB master tasks, serial peer, scenario tasks.
// Assumes the register map and bit layout of the shared defines.
`include "ubtr_defs.svh"
`default_nettype none
module tb_uart_baud_tx_rx_sequencing;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic        sin;
    logic        sout;
    logic        asout;
    logic        irq;
    logic [9:0]  f;
    int          n_errors;
    int          checks;
    ubtr_top ubtr_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_in_pin(sin), .alt_serial_in_pin(1'b1),
        .serial_out_pin(sout), .alt_serial_out_pin(asout), .irq(irq));
    ubtr_peer ubtr_peer_inst (.pclk(pclk), .line_in(sout), .line_out(sin));
    // One APB transfer; it holds the request until pready is sampled.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait count is assumed; only the watchdog ends a stuck wait.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Normal-speed transmit with enable interrupt; bit is 32 cycles.
    task automatic t_tx;
        apb(1'b1, `UBTR_A_IEN, 32'h0000_0007);
        apb(1'b1, `UBTR_A_DIV, 32'h0000_0001);
        apb(1'b1, `UBTR_A_CTRL, 32'h0000_0001);
        apb(1'b0, `UBTR_A_ISTAT, 32'h0);
        chk("tx_status", rd & 32'h1, 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        fork
            apb(1'b1, `UBTR_A_TXW, 32'h0000_00A5);
            ubtr_peer_inst.recv(32, f);
        join
        chk("tx_frame", {22'h0, f}, {22'h0, 1'b1, 8'hA5, 1'b0});
    endtask
    // High speed, then five chars into a four-deep receive queue.
    task automatic t_hs_rx;
        apb(1'b1, `UBTR_A_MODE, 32'h0000_0008);
        fork
            apb(1'b1, `UBTR_A_TXW, 32'h0000_003C);
            ubtr_peer_inst.recv(8, f);
        join
        chk("hs_frame", {22'h0, f}, {22'h0, 1'b1, 8'h3C, 1'b0});
        for (int i = 0; i < 5; i++) ubtr_peer_inst.send(8'(8'h11 + i), 8);
        repeat (16) @(posedge pclk);
        apb(1'b0, `UBTR_A_ISTAT, 32'h0);
        chk("rx_status", rd & 32'h2, 32'h2);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, `UBTR_A_RXW, 32'h0);
            chk("rx_data", rd & 32'h1FF, 32'(8'h11 + i));
        end
        apb(1'b0, `UBTR_A_CTRL, 32'h0);
        chk("overrun_held", rd & 32'h40, 32'h40);
        apb(1'b1, `UBTR_A_CTRL, 32'h0000_0001);
        apb(1'b0, `UBTR_A_CTRL, 32'h0);
        chk("overrun_clr", rd & 32'h40, 32'h0);
    endtask
    // Break with a non-zero dummy byte, then the queued sync byte.
    task automatic t_brk;
        apb(1'b1, `UBTR_A_CTRL, 32'h0000_0003);
        fork
            begin
                apb(1'b1, `UBTR_A_TXW, 32'h0000_00FF);
                apb(1'b1, `UBTR_A_TXW, 32'h0000_0055);
            end
            ubtr_peer_inst.recv(8, f);
        join
        chk("break_low", {22'h0, f}, 32'h0);
        // The break is longer than the ten sampled bits; wait it out.
        while (sout !== 1'b1) @(posedge pclk);
        ubtr_peer_inst.recv(8, f);
        chk("sync_frame", {22'h0, f}, {22'h0, 1'b1, 8'h55, 1'b0});
        apb(1'b0, `UBTR_A_CTRL, 32'h0);
        chk("break_auto_clr", rd & 32'h2, 32'h0);
    endtask
    // Character queued while disabled, sent on alternate pins at enable.
    task automatic t_alt;
        apb(1'b1, `UBTR_A_CTRL, 32'h0000_0000);
        apb(1'b1, `UBTR_A_MODE, 32'h0000_0408);
        apb(1'b1, `UBTR_A_TXW, 32'h0000_0000);
        chk("held_off", {31'h0, asout}, 32'h1);
        apb(1'b1, `UBTR_A_CTRL, 32'h0000_0001);
        for (int k = 0; k < 12 && asout !== 1'b0; k++) @(posedge pclk);
        chk("alt_tx_low", {31'h0, asout}, 32'h0);
        chk("pri_tx_idle", {31'h0, sout}, 32'h1);
    endtask
    // Free-running 40 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Hang guard, far beyond the thousand or so cycles the run needs.
    initial begin
        repeat (30000) @(posedge pclk);
        n_errors++;
        give_verdict();
    end
    // Reset, reset values, unmapped access, then the scenarios.
    initial begin
        n_errors = 0;
        checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `UBTR_A_MODE, 32'h0);
        chk("mode_rst", rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        t_tx();
        t_hs_rx();
        t_brk();
        t_alt();
        give_verdict();
    end
endmodule
`default_nettype wire
